/* File: src/lgp_led_gpio_pin_config.sv */
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module lgp_led_gpio_pin_config #(
	parameter bit LATER_VARIANT = 1'b1
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// APB slave
	input wire lgp_pkg::lgp_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// EEPROM image and resets
	input wire logic eeprom_present,
	input wire logic eeprom_load_done,
	input wire logic eeprom_led_select,
	input wire logic usb_reset,
	input wire logic lite_reset,
	// Internal status sources
	input wire lgp_pkg::lgp_led_status_t led_status,
	input wire lgp_pkg::lgp_mii_mirror_t mii_mirror,
	// Pins
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	// Events
	output logic irq,
	output logic wake_event
);

	// ==========================================================
	// Pin input synchroniser
	logic [2:0] pin_meta_reg, pin_meta_next;
	logic [2:0] pin_sync_reg, pin_sync_next;
	logic [2:0] pin_prev_reg, pin_prev_next;
	logic [1:0] settle_reg, settle_next;
	logic pin_settled;

	always_comb begin
		pin_meta_next = pin_in;
		pin_sync_next = pin_meta_reg;
		pin_prev_next = pin_sync_reg;

		// The history flop restarts at zero while idle pins sit high on their pull-ups;
		// edges are trusted only once all three stages hold real samples
		if (settle_reg != lgp_pkg::SETTLE_DONE) begin
			settle_next = settle_reg + 2'h1;
		end else begin
			settle_next = settle_reg;
		end
		pin_settled = settle_reg == lgp_pkg::SETTLE_DONE;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_meta_reg <= lgp_pkg::PIN_VEC_RESET;
			pin_sync_reg <= lgp_pkg::PIN_VEC_RESET;
			pin_prev_reg <= lgp_pkg::PIN_VEC_RESET;
			settle_reg <= lgp_pkg::SETTLE_RESET;
		end else if (clk_en) begin
			pin_meta_reg <= pin_meta_next;
			pin_sync_reg <= pin_sync_next;
			pin_prev_reg <= pin_prev_next;
			settle_reg <= settle_next;
		end
	end

	// ==========================================================
	// Register file and APB slave
	logic [2:0][1:0] func_reg, func_next;
	logic [2:0] buf_reg, buf_next;
	logic [2:0] dir_reg, dir_next;
	logic [2:0] data_reg, data_next;
	logic led_meaning_select_reg, led_meaning_select_next;
	logic image_sel_reg, image_sel_next;
	logic duplex_true_reg, duplex_true_next;
	logic [2:0] wake_en_reg, wake_en_next;
	logic [2:0] irq_stat_reg, irq_stat_next;
	logic [2:0] irq_mask_reg, irq_mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic wake_reg, wake_next;

	logic [2:0] pin_is_input;
	logic [2:0] pin_change;
	logic access, commit, hit_cfg, hit_stat, hit_mask, hit_wake, hit_ledc, mapped;
	logic [31:0] read_word;

	always_comb begin
		// A pin is an event source only as a plain input
		for (int i = 0; i < lgp_pkg::NPINS; i++) begin
			pin_is_input[i] = (func_reg[i] == lgp_pkg::FUNC_GPIO) && !dir_reg[i];
		end
		pin_change = (pin_sync_reg ^ pin_prev_reg) & pin_is_input & {lgp_pkg::NPINS{pin_settled}};
	end

	always_comb begin
		access = apb_req.psel && apb_req.penable;
		commit = access && pready_reg;
		hit_cfg = apb_req.paddr[11:2] == lgp_pkg::ADDR_CFG[11:2];
		hit_stat = apb_req.paddr[11:2] == lgp_pkg::ADDR_IRQ_STAT[11:2];
		hit_mask = apb_req.paddr[11:2] == lgp_pkg::ADDR_IRQ_MASK[11:2];
		hit_wake = apb_req.paddr[11:2] == lgp_pkg::ADDR_WAKE_EN[11:2];
		hit_ledc = apb_req.paddr[11:2] == lgp_pkg::ADDR_LED_CTRL[11:2];
		mapped = hit_cfg || hit_stat || hit_mask || hit_wake || hit_ledc;

		// Unlisted bits stay zero, so reserved fields read back as zero
		read_word = lgp_pkg::WORD_ZERO;
		if (hit_cfg) begin
			read_word[lgp_pkg::LED_MEANING_SELECT_BIT] = led_meaning_select_reg;
			for (int i = 0; i < lgp_pkg::NPINS; i++) begin
				read_word[lgp_pkg::FUNC_LSB + lgp_pkg::FUNC_STRIDE * i +: 2] = func_reg[i];
			end
			read_word[lgp_pkg::BUF_LSB +: 3] = buf_reg;
			read_word[lgp_pkg::DIR_LSB +: 3] = dir_reg;
			read_word[lgp_pkg::DATA_LSB +: 3] = pin_sync_reg;
		end else if (hit_stat) begin
			read_word[2:0] = irq_stat_reg;
		end else if (hit_mask) begin
			read_word[2:0] = irq_mask_reg;
		end else if (hit_wake) begin
			read_word[2:0] = wake_en_reg;
		end else if (hit_ledc) begin
			read_word[lgp_pkg::DUPLEX_TRUE_BIT] = duplex_true_reg;
		end

		func_next = func_reg;
		buf_next = buf_reg;
		dir_next = dir_reg;
		data_next = data_reg;
		led_meaning_select_next = led_meaning_select_reg;
		image_sel_next = image_sel_reg;
		duplex_true_next = duplex_true_reg;

		if (commit && apb_req.pwrite) begin
			if (hit_cfg) begin
				led_meaning_select_next = apb_req.pwdata[lgp_pkg::LED_MEANING_SELECT_BIT];
				for (int i = 0; i < lgp_pkg::NPINS; i++) begin
					func_next[i] = apb_req.pwdata[lgp_pkg::FUNC_LSB + lgp_pkg::FUNC_STRIDE * i +: 2];
				end
				buf_next = apb_req.pwdata[lgp_pkg::BUF_LSB +: 3];
				dir_next = apb_req.pwdata[lgp_pkg::DIR_LSB +: 3];
				data_next = apb_req.pwdata[lgp_pkg::DATA_LSB +: 3];
			end
			if (hit_ledc) begin
				duplex_true_next = apb_req.pwdata[lgp_pkg::DUPLEX_TRUE_BIT];
			end
		end

		// EEPROM image tracks the last load; without EEPROM it is zero
		if (eeprom_load_done) begin
			image_sel_next = eeprom_present && eeprom_led_select;
			led_meaning_select_next = eeprom_present && eeprom_led_select;
		end
		// Functional resets beat a same-cycle register write
		if (usb_reset || lite_reset) begin
			led_meaning_select_next = eeprom_present ? image_sel_reg : lgp_pkg::LED_MEANING_SELECT_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			func_reg <= {lgp_pkg::FUNC_RESET, lgp_pkg::FUNC_RESET, lgp_pkg::FUNC_RESET};
			buf_reg <= lgp_pkg::BUF_RESET;
			dir_reg <= lgp_pkg::DIR_RESET;
			data_reg <= lgp_pkg::DATA_RESET;
			// EEPROM load after reset overrides this value
			led_meaning_select_reg <= lgp_pkg::LED_MEANING_SELECT_RESET;
			image_sel_reg <= lgp_pkg::LED_MEANING_SELECT_RESET;
			duplex_true_reg <= 1'b0;
		end else if (clk_en) begin
			func_reg <= func_next;
			buf_reg <= buf_next;
			dir_reg <= dir_next;
			data_reg <= data_next;
			led_meaning_select_reg <= led_meaning_select_next;
			image_sel_reg <= image_sel_next;
			duplex_true_reg <= duplex_true_next;
		end
	end

	// ==========================================================
	// Bus answer
	always_comb begin
		// One wait state: answer is raised in the second access cycle
		pready_next = access && !pready_reg;
		// Unmapped addresses answer with an error and leave every register alone
		pslverr_next = access && !pready_reg && !mapped;
		// Read data is latched with the answer and held until the next access
		prdata_next = prdata_reg;
		if (access && !pready_reg) begin
			prdata_next = apb_req.pwrite ? lgp_pkg::WORD_ZERO : read_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prdata_reg <= lgp_pkg::WORD_ZERO;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (clk_en) begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ==========================================================
	// Interrupt and wake events
	always_comb begin
		wake_en_next = wake_en_reg;
		irq_mask_next = irq_mask_reg;
		irq_stat_next = irq_stat_reg;

		// Mask and wake enable land on the bus commit edge like the config word
		if (commit && apb_req.pwrite && hit_mask) begin
			irq_mask_next = apb_req.pwdata[2:0];
		end
		if (commit && apb_req.pwrite && hit_wake) begin
			wake_en_next = apb_req.pwdata[2:0];
		end

		// Read clears the status; a change in the same cycle still lands
		if (commit && !apb_req.pwrite && hit_stat) begin
			irq_stat_next = lgp_pkg::PIN_VEC_RESET;
		end
		irq_stat_next = irq_stat_next | pin_change;

		// Level taken from the next status, so it rises on the same edge as the status bit
		irq_next = |(irq_stat_next & irq_mask_next);
		// Pulse only for a pin that is a plain input and enabled for wake
		wake_next = |(pin_change & wake_en_reg);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wake_en_reg <= lgp_pkg::PIN_VEC_RESET;
			irq_stat_reg <= lgp_pkg::PIN_VEC_RESET;
			irq_mask_reg <= lgp_pkg::PIN_VEC_RESET;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else if (clk_en) begin
			wake_en_reg <= wake_en_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
		end
	end

	// ==========================================================
	// LED meanings
	logic [2:0] led_ind;
	logic [2:0] mirror_a;
	logic [2:0] mirror_b;

	always_comb begin
		// Pin 2 is ten, pin 1 nine, pin 0 eight
		led_ind[2] = led_status.speed;
		if (led_meaning_select_reg) begin
			led_ind[1] = led_status.link;
			led_ind[0] = led_status.activity;
		end else begin
			// Link lit steady, blinks off while traffic runs
			led_ind[1] = led_status.link && !led_status.activity;
			led_ind[0] = duplex_true_reg ? led_status.full_duplex : led_status.activity;
		end
		if (!LATER_VARIANT) begin
			// Earlier variant ignores led select on pins nine and eight
			led_ind[1] = led_status.link && !led_status.activity;
			led_ind[0] = duplex_true_reg ? led_status.full_duplex : led_status.activity;
		end
		// Pin ten: RXD0 or RXD3
		mirror_a[2] = mii_mirror.rxd[0];
		mirror_b[2] = mii_mirror.rxd[3];
		// Pin nine: RXD1 or the PHY reset
		mirror_a[1] = mii_mirror.rxd[1];
		mirror_b[1] = mii_mirror.phy_reset_n;
		// Pin eight: RXD2 or CRS
		mirror_a[0] = mii_mirror.rxd[2];
		mirror_b[0] = mii_mirror.crs;
	end

	// ==========================================================
	// Pin drivers
	logic [2:0] pin_out_reg, pin_out_next;
	logic [2:0] pin_oe_reg, pin_oe_next;
	logic [2:0] level;
	logic [2:0] drive;

	generate
		for (genvar g = 0; g < lgp_pkg::NPINS; g++) begin : g_pin
			always_comb begin
				case (func_reg[g])
					lgp_pkg::FUNC_GPIO: begin
						level[g] = data_reg[g];
						drive[g] = dir_reg[g];
					end
					lgp_pkg::FUNC_LED: begin
						// LEDs are active low on the pin
						level[g] = !led_ind[g];
						drive[g] = 1'b1;
					end
					lgp_pkg::FUNC_MIRROR_A: begin
						level[g] = mirror_a[g];
						drive[g] = 1'b1;
					end
					lgp_pkg::FUNC_MIRROR_B: begin
						level[g] = mirror_b[g];
						drive[g] = 1'b1;
					end
					default: begin
						level[g] = 1'b0;
						drive[g] = 1'b0;
					end
				endcase
				// Open drain only pulls low; high comes from the board pull-up
				pin_out_next[g] = buf_reg[g] ? level[g] : 1'b0;
				pin_oe_next[g] = drive[g] && (buf_reg[g] || !level[g]);
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_out_reg <= lgp_pkg::PIN_VEC_RESET;
			pin_oe_reg <= lgp_pkg::PIN_VEC_RESET;
		end else if (clk_en) begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign irq = irq_reg;
	assign wake_event = wake_reg;

endmodule : lgp_led_gpio_pin_config

/* File: src/lgp_pkg.sv */
package lgp_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned NPINS = 3;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ==========================================================
	// Register byte addresses
	localparam logic [11:0] ADDR_CFG = 12'h024;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h040;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h044;
	localparam logic [11:0] ADDR_WAKE_EN = 12'h048;
	localparam logic [11:0] ADDR_LED_CTRL = 12'h04c;

	// ==========================================================
	// Field positions in the configuration and LED control words
	localparam int unsigned LED_MEANING_SELECT_BIT = 31;
	localparam int unsigned FUNC_LSB = 16;
	localparam int unsigned FUNC_STRIDE = 4;
	localparam int unsigned BUF_LSB = 8;
	localparam int unsigned DIR_LSB = 4;
	localparam int unsigned DATA_LSB = 0;
	localparam int unsigned DUPLEX_TRUE_BIT = 0;

	// ==========================================================
	// Pin function codes
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_LED = 2'h1;
	localparam logic [1:0] FUNC_MIRROR_A = 2'h2;
	localparam logic [1:0] FUNC_MIRROR_B = 2'h3;

	// ==========================================================
	// Reset values
	localparam logic [1:0] FUNC_RESET = 2'h0;
	localparam logic [2:0] BUF_RESET = 3'h0;
	localparam logic [2:0] DIR_RESET = 3'h0;
	localparam logic [2:0] DATA_RESET = 3'h0;
	localparam logic [2:0] PIN_VEC_RESET = 3'h0;
	localparam logic [1:0] SETTLE_RESET = 2'h0;
	localparam logic [1:0] SETTLE_DONE = 2'h3;
	localparam logic LED_MEANING_SELECT_RESET = 1'b0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lgp_apb_req_t;

	typedef struct packed {
		logic speed;
		logic link;
		logic activity;
		logic full_duplex;
	} lgp_led_status_t;

	typedef struct packed {
		logic [3:0] rxd;
		logic crs;
		logic phy_reset_n;
	} lgp_mii_mirror_t;

endpackage : lgp_pkg

/* File: verification/lgp_asserts.sv */
`timescale 1ns/10ps
module lgp_asserts (
	// Clock and reset
	input logic clk_sys,
	input logic rst_n,
	// Bus
	input lgp_pkg::lgp_apb_req_t apb_req,
	input logic [31:0] prdata,
	input logic pready,
	// Sources and pins
	input lgp_pkg::lgp_led_status_t led_status,
	input lgp_pkg::lgp_mii_mirror_t mii_mirror,
	input logic [2:0] pin_out,
	input logic [2:0] pin_oe,
	input logic wake_event
);
	// =====
	// Shadow of the written config, so pin checks need no internal probes
	logic [31:0] cfg_reg, cfg_next;
	logic [2:0] wk_reg, wk_next, gin, pp, mir, lvl;
	logic wr;
	always_comb begin
		wr = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;
		cfg_next = (wr && apb_req.paddr == lgp_pkg::ADDR_CFG) ? apb_req.pwdata : cfg_reg;
		wk_next = (wr && apb_req.paddr == lgp_pkg::ADDR_WAKE_EN) ? apb_req.pwdata[2:0] : wk_reg;
		for (int i = 0; i < 3; i++) begin
			gin[i] = cfg_reg[16 + 4 * i +: 2] == 2'h0 && !cfg_reg[4 + i];
			pp[i] = cfg_reg[16 + 4 * i +: 2] == 2'h0 && cfg_reg[4 + i] && cfg_reg[8 + i];
			mir[i] = cfg_reg[17 + 4 * i] & cfg_reg[8 + i];
		end
		lvl[0] = cfg_reg[16] ? mii_mirror.crs : mii_mirror.rxd[2];
		lvl[1] = cfg_reg[20] ? mii_mirror.phy_reset_n : mii_mirror.rxd[1];
		lvl[2] = cfg_reg[24] ? mii_mirror.rxd[3] : mii_mirror.rxd[0];
	end
	always_ff @(posedge clk_sys) begin
		cfg_reg <= rst_n ? cfg_next : 32'h0;
		wk_reg <= rst_n ? wk_next : 3'h0;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_access;
		apb_req.psel && apb_req.penable;
	endsequence
	read_answer_a: assert property (s_setup ##1 s_access |=> pready)
		else $error("pready not in second access cycle");
	reserved_zero_a: assert property (pready && !apb_req.pwrite && apb_req.paddr == lgp_pkg::ADDR_CFG
		|-> (prdata & 32'h00c0_f888) == 32'h0) else $error("reserved bits read nonzero");
	input_float_a: assert property (1'b1 |=> (pin_oe & $past(gin)) == 3'h0)
		else $error("input pin driven");
	gpio_drive_a: assert property (pp != 3'h0 |=> ((pin_out ^ $past(cfg_reg[2:0])) & $past(pp)) == 3'h0
		&& (~pin_oe & $past(pp)) == 3'h0) else $error("output pin not at data bit");
	open_drain_a: assert property (1'b1 |=> (pin_out & ~$past(cfg_reg[10:8])) == 3'h0)
		else $error("open-drain pin drove high");
	mirror_follow_a: assert property (mir != 3'h0 |=> ((pin_out ^ $past(lvl)) & $past(mir)) == 3'h0)
		else $error("mirror pin off its source");
	speed_led_a: assert property (cfg_reg[25:24] == 2'h1 && cfg_reg[10]
		|=> pin_out[2] == !$past(led_status.speed)) else $error("speed LED wrong");
	wake_input_a: assert property (wake_event |-> ($past(gin & wk_reg)) != 3'h0)
		else $error("wake from non-input pin");
endmodule : lgp_asserts
bind lgp_led_gpio_pin_config lgp_asserts lgp_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .led_status(led_status), .mii_mirror(mii_mirror), .pin_out(pin_out),
	.pin_oe(pin_oe), .wake_event(wake_event));

/* File: verification/lgp_board_model.sv */
`timescale 1ns/10ps
module lgp_board_model (
	// Device side
	input logic [2:0] pin_out,
	input logic [2:0] pin_oe,
	// Bench side
	input logic [2:0] ext_oe,
	input logic [2:0] ext_val,
	output logic [2:0] pin_in
);
	// =====
	// Line levels: pull-ups hold a released open-drain or LED line high
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : lgp_board_model

/* File: verification/lgp_led_gpio_pin_config_bench.sv */
`timescale 1ns/10ps
module lgp_led_gpio_pin_config_bench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	lgp_pkg::lgp_apb_req_t apb_req = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, wake_event, err;
	logic eeprom_present = 1'b0, eeprom_load_done = 1'b0, eeprom_led_select = 1'b0;
	logic usb_reset = 1'b0, lite_reset = 1'b0;
	lgp_pkg::lgp_led_status_t led_status = '0, l;
	lgp_pkg::lgp_mii_mirror_t mii_mirror = '0, m;
	logic [2:0] pin_in, pin_out, pin_oe, e;
	logic [2:0] ext_oe = 3'h0, ext_val = 3'h0;
	int mismatches = 0, n_checks = 0, cycles = 0, wakes = 0;

	always #25 clk_sys = ~clk_sys;

	lgp_led_gpio_pin_config lgp_led_gpio_pin_config_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
		.apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_present(eeprom_present),
		.eeprom_load_done(eeprom_load_done), .eeprom_led_select(eeprom_led_select), .usb_reset(usb_reset),
		.lite_reset(lite_reset), .led_status(led_status), .mii_mirror(mii_mirror), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .wake_event(wake_event));
	lgp_board_model lgp_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
		.ext_val(ext_val), .pin_in(pin_in));

	// =====
	// Shared tasks
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		wakes += wake_event;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end

	task check(string name, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : check

	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task wait_n(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_n

	// =====
	// Scenarios
	task t_reset_regs;
		check("oe reset", pin_oe, 3'h0);
		apb(0, lgp_pkg::ADDR_CFG, 0);
		check("cfg reset", rd, 32'h7);
		apb(1, 12'h100, 32'hffff_ffff);
		check("unmapped err", err, 1);
		mii_mirror <= '1;
		apb(1, lgp_pkg::ADDR_CFG, 32'hffff_ffff);
		apb(0, lgp_pkg::ADDR_CFG, 0);
		check("cfg reserved", rd, 32'h8333_0777);
		$display("reset_regs done");
	endtask : t_reset_regs

	task t_gpio;
		apb(1, lgp_pkg::ADDR_CFG, 32'h575);
		wait_n(3);
		check("pin level", pin_in, 3'h5);
		check("pin oe", pin_oe, 3'h7);
		apb(0, lgp_pkg::ADDR_CFG, 0);
		check("data read", rd, 32'h575);
		apb(1, lgp_pkg::ADDR_CFG, 32'h572);
		wait_n(3);
		check("od release oe", pin_oe, 3'h5);
		check("od release level", pin_in, 3'h2);
		$display("gpio done");
	endtask : t_gpio

	task t_mirror;
		for (int c = 0; c < 2; c++) begin
			apb(1, lgp_pkg::ADDR_CFG, c ? 32'h0322_0700 : 32'h0233_0700);
			for (int k = 0; k < 4; k++) begin
				mii_mirror <= 6'h15 ^ 6'(k * 11);
				wait_n(2);
				m = mii_mirror;
				e = c ? {m.rxd[3], m.rxd[1], m.rxd[2]} : {m.rxd[0], m.phy_reset_n, m.crs};
				check("mirror pins", pin_out, e);
			end
		end
		$display("mirror done");
	endtask : t_mirror

	task t_led;
		for (int s = 0; s < 3; s++) begin
			apb(1, lgp_pkg::ADDR_LED_CTRL, s == 1);
			apb(1, lgp_pkg::ADDR_CFG, {s == 2, 31'h0111_0700});
			for (int k = 0; k < 16; k++) begin
				led_status <= 4'(k);
				wait_n(2);
				l = led_status;
				e[2] = !l.speed;
				e[1] = (s == 2) ? !l.link : !(l.link & !l.activity);
				e[0] = (s == 1) ? !l.full_duplex : !l.activity;
				check("led pins", pin_out, e);
			end
		end
		$display("led done");
	endtask : t_led

	task t_eeprom;
		eeprom_present <= 1'b1;
		eeprom_led_select <= 1'b1;
		eeprom_load_done <= 1'b1;
		@(posedge clk_sys);
		eeprom_load_done <= 1'b0;
		apb(0, lgp_pkg::ADDR_CFG, 0);
		check("select loaded", 32'(rd[31]), 1);
		for (int r = 0; r < 3; r++) begin
			eeprom_present <= r < 2;
			apb(1, lgp_pkg::ADDR_CFG, {r == 2, 31'h0});
			{lite_reset, usb_reset} <= (r == 1) ? 2'h2 : 2'h1;
			@(posedge clk_sys);
			{lite_reset, usb_reset} <= 2'h0;
			apb(0, lgp_pkg::ADDR_CFG, 0);
			check("select restored", 32'(rd[31]), r < 2);
		end
		$display("eeprom done");
	endtask : t_eeprom

	task t_irq;
		apb(1, lgp_pkg::ADDR_CFG, 0);
		apb(1, lgp_pkg::ADDR_IRQ_MASK, 1);
		apb(1, lgp_pkg::ADDR_WAKE_EN, 2);
		apb(0, lgp_pkg::ADDR_IRQ_STAT, 0);
		wait_n(1);
		check("irq cleared", irq, 0);
		ext_oe <= 3'h7;
		ext_val <= 3'h6;
		wait_n(5);
		check("irq raised", irq, 1);
		check("no wake", wakes, 0);
		apb(0, lgp_pkg::ADDR_CFG, 0);
		check("input read", rd, 32'h6);
		apb(0, lgp_pkg::ADDR_IRQ_STAT, 0);
		check("status", rd, 32'h1);
		ext_val <= 3'h4;
		wait_n(5);
		check("masked irq", irq, 0);
		check("wake pulse", wakes, 1);
		apb(1, lgp_pkg::ADDR_CFG, 32'h22);
		ext_val <= 3'h6;
		wait_n(5);
		check("output no wake", wakes, 1);
		$display("irq done");
	endtask : t_irq

	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_n(4);
		t_reset_regs();
		t_gpio();
		t_mirror();
		t_led();
		t_eeprom();
		t_irq();
		final_report();
	end
endmodule : lgp_led_gpio_pin_config_bench
